// [rtl/mgsc_gain_latch.sv]
// one gain amplifier's code latch with source select
`timescale 1ns/10ps
`include "mgsc_regs.svh"
module mgsc_gain_latch #(
  parameter int GAIN_W = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic latch_pin,
  input wire logic [GAIN_W-1:0] par_pins,
  input wire logic [GAIN_W-1:0] serial_code,
  input wire logic par_mode,
  output logic [GAIN_W-1:0] code_out,
  output logic [`MGSC_HALFDB_W-1:0] halfdb_out
);

  generate
    if (GAIN_W != `MGSC_GAIN_W) begin : g_bad_width
      $error("gain width must be six");
    end
  endgenerate

  mgsc_pkg::mgsc_gain_st_t st_q;
  mgsc_pkg::mgsc_gain_st_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [GAIN_W-1:0] pick;
    pick = '0;
    st_d = st_q;
    st_d.latch_sync = {st_q.latch_sync[0], latch_pin};
    st_d.pin_sync = {st_q.pin_sync[0], par_pins};
    // source choice
    pick = par_mode ? st_q.pin_sync[1] : serial_code;
    // commit while latch high, else hold
    if (st_q.latch_sync[1]) begin
      st_d.code = pick;
      // code 0 = +22 dB, each step -0.5 dB
      st_d.halfdb = `MGSC_HALFDB_TOP - {1'b0, pick};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{latch_sync: 2'h0, pin_sync: '0, code: `MGSC_GAIN_RESET,
                halfdb: `MGSC_HALFDB_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign code_out = st_q.code;
  assign halfdb_out = st_q.halfdb;

endmodule

// [rtl/mgsc_pkg.sv]
// state types of the serial control block
`include "mgsc_regs.svh"
package mgsc_pkg;
  typedef logic [`MGSC_WORD_W-1:0] mgsc_word_t;

  typedef struct packed {
    mgsc_word_t shift;
  } mgsc_link_st_t;

  typedef struct packed {
    logic [2:0] strobe_pipe;
    mgsc_word_t [`MGSC_NUM_LATCH-1:0] latch;
    logic [`MGSC_SEL_W-1:0] last_sel;
  } mgsc_core_st_t;

  typedef struct packed {
    logic [1:0] latch_sync;
    logic [1:0][`MGSC_GAIN_W-1:0] pin_sync;
    logic [`MGSC_GAIN_W-1:0] code;
    logic [`MGSC_HALFDB_W-1:0] halfdb;
  } mgsc_gain_st_t;
endpackage

// [rtl/mgsc_regs.svh]
// latch indices, field positions and constants of the serial control block
// Behaviour
// - msb first, one bit per rising serial clock edge
// - strobe rise copies word into one latch
// - low four bits select destination latch
// - latch 13 holds both balun cutoff fields
// - latch 13 bits 26:25 mixer lo bias
// - latch 13 bits 24:22 v to i bias
// - latch 13 bits 5,4 mixer enables
// - latch 7 bit 22 picks gain source
// - serial gain codes from latch 14
// - parallel gain code from six pins
// - latch 14 bits 5,4 amplifier power-down
// - gain code linear, half dB steps
// - gain commits while latch input high
// - shift only while strobe low, keep 32
// - serial readback output pin provided
// - select code maps straight to 0..15
`ifndef MGSC_REGS_SVH
`define MGSC_REGS_SVH
`define MGSC_WORD_W 32
`define MGSC_NUM_LATCH 16
`define MGSC_SEL_W 4
`define MGSC_SEL_MSB 3
`define MGSC_SEL_LSB 0
`define MGSC_LATCH_RESET 32'h00000000
`define MGSC_IDX_GAIN_SRC 4'h7
`define MGSC_IDX_MIX_BIAS 4'hD
`define MGSC_IDX_AMP_GAIN 4'hE
`define MGSC_GSRC_BIT 22
`define MGSC_CIN_MSB 12
`define MGSC_CIN_LSB 10
`define MGSC_COUT_MSB 9
`define MGSC_COUT_LSB 7
`define MGSC_LOB_MSB 26
`define MGSC_LOB_LSB 25
`define MGSC_VTOI_MSB 24
`define MGSC_VTOI_LSB 22
`define MGSC_MIX0_EN_BIT 5
`define MGSC_MIX1_EN_BIT 4
`define MGSC_GAIN0_MSB 17
`define MGSC_GAIN0_LSB 12
`define MGSC_GAIN1_MSB 11
`define MGSC_GAIN1_LSB 6
`define MGSC_AMP0_PD_BIT 5
`define MGSC_AMP1_PD_BIT 4
`define MGSC_GAIN_W 6
`define MGSC_HALFDB_W 7
`define MGSC_HALFDB_TOP 7'h2C
`define MGSC_GAIN_RESET 6'h00
`define MGSC_HALFDB_RESET 7'h2C
`endif

// [rtl/mgsc_serial_ctrl.sv]
// three-wire serial control latches for mixers, baluns and gain amplifiers
`timescale 1ns/10ps
`include "mgsc_regs.svh"
module mgsc_serial_ctrl #(
  parameter int NUM_LATCH = 16,
  parameter int GAIN_W = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic gain_latch_ch0,
  input wire logic gain_latch_ch1,
  input wire logic [GAIN_W-1:0] parallel_gain_pins_ch0,
  input wire logic [GAIN_W-1:0] parallel_gain_pins_ch1,
  output logic serial_readback_out,
  output logic [2:0] balun_in_cutoff,
  output logic [2:0] balun_out_cutoff,
  output logic [1:0] mixer_lo_bias,
  output logic [2:0] mixer_vtoi_bias,
  output logic mixer_ch0_en,
  output logic mixer_ch1_en,
  output logic amp_ch0_pd,
  output logic amp_ch1_pd,
  output logic gain_parallel_mode,
  output logic [GAIN_W-1:0] gain_code_ch0,
  output logic [GAIN_W-1:0] gain_code_ch1,
  output logic [`MGSC_HALFDB_W-1:0] gain_halfdb_ch0,
  output logic [`MGSC_HALFDB_W-1:0] gain_halfdb_ch1,
  output logic [`MGSC_SEL_W-1:0] last_dest_sel
);

  generate
    if (NUM_LATCH != `MGSC_NUM_LATCH) begin : g_bad_latch
      $error("latch count must be sixteen");
    end
    if (GAIN_W != `MGSC_GAIN_W) begin : g_bad_gain
      $error("gain width must be six");
    end
  endgenerate

  mgsc_pkg::mgsc_link_st_t link_q;
  mgsc_pkg::mgsc_link_st_t link_d;
  mgsc_pkg::mgsc_core_st_t core_q;
  mgsc_pkg::mgsc_core_st_t core_d;
  mgsc_pkg::mgsc_word_t src_word;
  mgsc_pkg::mgsc_word_t amp_word;

  ////////////////////////////////////////////////////////////////////////////
  // serial clock domain: shift register
  always_comb begin
    link_d = link_q;
    // shift while strobe low, oldest bit falls out
    if (!load_strobe) begin
      link_d.shift = {link_q.shift[`MGSC_WORD_W-2:0], sdata};
    end
  end

  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      link_q <= '{shift: `MGSC_LATCH_RESET};
    end else begin
      link_q <= link_d;
    end
  end

  // oldest held bit leaves first on readback
  assign serial_readback_out = link_q.shift[`MGSC_WORD_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // core domain: strobe sync, edge detect, latch load
  always_comb begin
    logic [`MGSC_SEL_W-1:0] sel;
    sel = '0;
    core_d = core_q;
    core_d.strobe_pipe = {core_q.strobe_pipe[1:0], load_strobe};
    // word is still while strobe high, so read it after the sync
    sel = link_q.shift[`MGSC_SEL_MSB:`MGSC_SEL_LSB];
    if (core_q.strobe_pipe[1] && !core_q.strobe_pipe[2]) begin
      core_d.latch[sel] = link_q.shift;
      core_d.last_sel = sel;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_q <= '{strobe_pipe: 3'h0, latch: '0, last_sel: 4'h0};
    end else begin
      core_q <= core_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode; other bits drive nothing
  assign src_word = core_q.latch[`MGSC_IDX_GAIN_SRC];
  assign amp_word = core_q.latch[`MGSC_IDX_AMP_GAIN];
  assign balun_in_cutoff =
    core_q.latch[`MGSC_IDX_MIX_BIAS][`MGSC_CIN_MSB:`MGSC_CIN_LSB];
  assign balun_out_cutoff =
    core_q.latch[`MGSC_IDX_MIX_BIAS][`MGSC_COUT_MSB:`MGSC_COUT_LSB];
  assign mixer_lo_bias =
    core_q.latch[`MGSC_IDX_MIX_BIAS][`MGSC_LOB_MSB:`MGSC_LOB_LSB];
  assign mixer_vtoi_bias =
    core_q.latch[`MGSC_IDX_MIX_BIAS][`MGSC_VTOI_MSB:`MGSC_VTOI_LSB];
  assign mixer_ch0_en =
    core_q.latch[`MGSC_IDX_MIX_BIAS][`MGSC_MIX0_EN_BIT];
  assign mixer_ch1_en =
    core_q.latch[`MGSC_IDX_MIX_BIAS][`MGSC_MIX1_EN_BIT];
  assign amp_ch0_pd = amp_word[`MGSC_AMP0_PD_BIT];
  assign amp_ch1_pd = amp_word[`MGSC_AMP1_PD_BIT];
  assign gain_parallel_mode = src_word[`MGSC_GSRC_BIT];
  assign last_dest_sel = core_q.last_sel;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel gain latches
  mgsc_gain_latch #(
    .GAIN_W(GAIN_W)
  ) u_gain_ch0 (
    .clk(clk),
    .reset_n(reset_n),
    .latch_pin(gain_latch_ch0),
    .par_pins(parallel_gain_pins_ch0),
    .serial_code(amp_word[`MGSC_GAIN0_MSB:`MGSC_GAIN0_LSB]),
    .par_mode(src_word[`MGSC_GSRC_BIT]),
    .code_out(gain_code_ch0),
    .halfdb_out(gain_halfdb_ch0)
  );

  mgsc_gain_latch #(
    .GAIN_W(GAIN_W)
  ) u_gain_ch1 (
    .clk(clk),
    .reset_n(reset_n),
    .latch_pin(gain_latch_ch1),
    .par_pins(parallel_gain_pins_ch1),
    .serial_code(amp_word[`MGSC_GAIN1_MSB:`MGSC_GAIN1_LSB]),
    .par_mode(src_word[`MGSC_GSRC_BIT]),
    .code_out(gain_code_ch1),
    .halfdb_out(gain_halfdb_ch1)
  );

endmodule

// [test/mgsc_host_model.sv]
// host driving the three-wire serial port
`timescale 1ns/10ps
module mgsc_host_model (
  output logic sclk,
  output logic sdata,
  output logic load_strobe
);
  initial begin
    sclk = 0;
    sdata = 0;
    load_strobe = 0;
  end
  // n bits msb first; clock idles low between frames
  task automatic send(input logic [39:0] w, input int n, input int hp);
    load_strobe = 0;
    for (int i = n - 1; i >= 0; i--) begin
      sdata = w[i];
      #hp sclk = 1;
      #hp sclk = 0;
    end
    #hp load_strobe = 1;
    sdata = ~w[0];
    #500;
  endtask
endmodule

// [test/mgsc_serial_ctrl_asserts.sv]
// checker for the serial control block
`timescale 1ns/10ps
module mgsc_sc_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic gain_latch_ch0,
  input wire logic gain_latch_ch1,
  input wire logic [5:0] parallel_gain_pins_ch1,
  input wire logic serial_readback_out,
  input wire logic [2:0] balun_in_cutoff,
  input wire logic [2:0] balun_out_cutoff,
  input wire logic [1:0] mixer_lo_bias,
  input wire logic [2:0] mixer_vtoi_bias,
  input wire logic mixer_ch0_en,
  input wire logic mixer_ch1_en,
  input wire logic amp_ch0_pd,
  input wire logic amp_ch1_pd,
  input wire logic gain_parallel_mode,
  input wire logic [5:0] gain_code_ch0,
  input wire logic [5:0] gain_code_ch1,
  input wire logic [6:0] gain_halfdb_ch0,
  input wire logic [6:0] gain_halfdb_ch1,
  input wire logic [3:0] last_dest_sel
);
  logic [31:0] sh_q;
  wire logic [12:0] f = {balun_in_cutoff, balun_out_cutoff, mixer_lo_bias,
    mixer_vtoi_bias, mixer_ch0_en, mixer_ch1_en};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // shadow of the link shift register
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) sh_q <= '0;
    else if (!load_strobe) sh_q <= {sh_q[30:0], sdata};
  end
  //////////////////////////////////////////////////////////////////////////
  a_sel_map: assert property ($rose(load_strobe) |-> ##3
    last_dest_sel == $past(sh_q[3:0], 3)) else $error("wrong latch index");
  a_mix_fields: assert property (
    $rose(load_strobe) && sh_q[3:0] == 4'hD
    |-> ##3 f == $past({sh_q[12:7], sh_q[26:22], sh_q[5:4]}, 3))
    else $error("mixer fields wrong");
  a_gain_src: assert property (
    $rose(load_strobe) && sh_q[3:0] == 4'h7
    |-> ##3 gain_parallel_mode == $past(sh_q[22], 3))
    else $error("gain source wrong");
  a_amp_pd: assert property (
    $rose(load_strobe) && sh_q[3:0] == 4'hE
    |-> ##3 {amp_ch0_pd, amp_ch1_pd} == $past(sh_q[5:4], 3))
    else $error("power-down wrong");
  a_fields_hold: assert property (
    $changed({f, amp_ch0_pd, amp_ch1_pd, gain_parallel_mode})
    |-> $past(load_strobe, 3) && !$past(load_strobe, 4))
    else $error("field moved without load");
  a_halfdb_map: assert property (
    gain_halfdb_ch0 == 7'h2C - gain_code_ch0
    && gain_halfdb_ch1 == 7'h2C - gain_code_ch1) else $error("gain map");
  a_code_hold: assert property ($changed(gain_code_ch0)
    |-> $past(gain_latch_ch0, 3)) else $error("code moved unlatched");
  a_par_code: assert property (
    $past(gain_latch_ch1, 3) && gain_parallel_mode
    && $past(gain_parallel_mode)
    && $past(parallel_gain_pins_ch1, 3) == $past(parallel_gain_pins_ch1, 4)
    |-> gain_code_ch1 == $past(parallel_gain_pins_ch1, 3))
    else $error("pin code wrong");
  a_readback: assert property (
    serial_readback_out == sh_q[31]) else $error("readback wrong");
  cover property ($rose(load_strobe));
  cover property (gain_parallel_mode && gain_latch_ch1);
  cover property ($changed(gain_code_ch0));
endmodule
bind mgsc_serial_ctrl mgsc_sc_chk chk (.*);

// [test/tb_mgsc_serial_ctrl.sv]
// self-checking bench for the serial control block
`timescale 1ns/10ps
module tb_mgsc_serial_ctrl;
  logic clk = 0, reset_n = 0, gain_latch_ch0 = 0, gain_latch_ch1 = 0;
  logic sclk, sdata, load_strobe, serial_readback_out, mixer_ch0_en;
  logic mixer_ch1_en, amp_ch0_pd, amp_ch1_pd, gain_parallel_mode;
  logic [5:0] parallel_gain_pins_ch0 = 0, parallel_gain_pins_ch1 = 0;
  logic [5:0] gain_code_ch0, gain_code_ch1, c0 = 0, c1 = 0;
  logic [2:0] balun_in_cutoff, balun_out_cutoff, mixer_vtoi_bias;
  logic [1:0] mixer_lo_bias;
  logic [6:0] gain_halfdb_ch0, gain_halfdb_ch1;
  logic [3:0] last_dest_sel, sel = 0;
  logic [31:0] x = 32'hA619, r7 = 0, r13 = 0, r14 = 0;
  logic [46:0] q[$];
  logic rb = 0;
  int miscompares = 0, check_count = 0;
  event chk_ev;
  wire logic [46:0] obs = {last_dest_sel, balun_in_cutoff, balun_out_cutoff,
    mixer_lo_bias, mixer_vtoi_bias, mixer_ch0_en, mixer_ch1_en, amp_ch0_pd,
    amp_ch1_pd, gain_parallel_mode, gain_code_ch0, gain_code_ch1,
    gain_halfdb_ch0, gain_halfdb_ch1, serial_readback_out};
  mgsc_serial_ctrl uut (.*);
  mgsc_host_model host (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));
  initial forever #50 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic check();
    q.push_back({sel, r13[12:7], r13[26:22], r13[5:4], r14[5:4], r7[22], c0,
      c1, 7'h2C - {1'b0, c0}, 7'h2C - {1'b0, c1}, rb});
    ->chk_ev;
    #1;
  endtask
  task automatic wr(input logic [31:0] w, input int n, input int hp);
    x = xs(x);
    host.send({x[7:0], w}, n, hp);
    sel = w[3:0];
    rb = w[31];
    if (sel == 4'h7) r7 = w;
    if (sel == 4'hD) r13 = w;
    if (sel == 4'hE) r14 = w;
  endtask
  task automatic commit(input logic [1:0] ch);
    @(posedge clk) #1 {gain_latch_ch1, gain_latch_ch0} = ch;
    repeat (5) @(posedge clk);
    #1 {gain_latch_ch1, gain_latch_ch0} = 2'b00;
    repeat (4) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(chk_ev) begin
    check_count++;
    if (obs !== q.pop_front()) begin
      miscompares++;
      $display("mismatch %0t outputs differ %h", $time, obs);
    end
  end
  initial begin
    #200000 miscompares++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 reset_n = 1;
    check();
    for (int i = 0; i < 16; i++) begin
      wr({x[31:4], i[3:0]}, 32, 24);
      check();
    end
    wr({x[31:23], 1'b0, x[21:4], 4'h7}, 32, 24);
    wr({x[31:4], 4'hE}, 40, 24);
    check();
    commit(2'b01);
    c0 = r14[17:12];
    check();
    commit(2'b10);
    c1 = r14[11:6];
    check();
    wr({x[31:23], 1'b1, x[21:4], 4'h7}, 32, 24);
    @(posedge clk) #1 parallel_gain_pins_ch0 = 6'h3F;
    parallel_gain_pins_ch1 = 6'h00;
    commit(2'b11);
    {c0, c1} = 12'hFC0;
    check();
    @(posedge clk) #1 {parallel_gain_pins_ch0, parallel_gain_pins_ch1} = x[11:0];
    repeat (6) @(posedge clk);
    check();
    stop_test();
  end
endmodule
